// >>> rtl/cmd_decoder_pkg.sv
// constants for the satellite control bus slave command decoder
// assumes a byte-level frame receiver in front and a byte transmitter behind
// Contract
// R01 - 0x01 clears reset flag, framing reply
// R02 - 0x04 sets contention flag bit 7
// R03 - 0x06 clears contention flag bit 7
// R04 - 0x05 returns address only while contending
// R05 - 0x07 returns address unless contending
// R06 - 0x08 writes address only while contending
// R07 - 0x09 writes address unless contending
// R08 - 0x10 returns status register byte
// R09 - 0x11 capability byte, 0x14 path byte
// R10 - 0x20/0x24 clear/set band bit 4
// R11 - 0x21/0x25 clear/set polarization bit 5
// R12 - 0x22/0x26 clear/set satellite bit 6
// R13 - 0x23/0x27 clear/set option bit 7
// R14 - 0x30 sleeps; ignore all but wake
// R15 - 0x31 wakes, clears sleep bit 1
// R16 - 0x38 data byte loads path bits 7:4
// R17 - 0x50 returns two frequency digit bytes
// R18 - 0x51 current band table entry nibble
// R19 - 0x52 low band table entry nibble
// R20 - 0x53 high band table entry nibble
// R21 - status bit 2 reports supply level; code latches supply_high only at init after reset release or 0x00
// R22 - reply only on framing 0xE2/0xE3
// R23 - accept listed addresses, framing E0..E7
// R24 - 0x00 resets decoder, sets reset flag
// R25 - unsupported commands ignored, no data
package cmd_decoder_pkg;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] CMD_CLR_RESET = 8'h01;
  localparam logic [7:0] CMD_SET_CONTEND = 8'h04;
  localparam logic [7:0] CMD_CONTEND = 8'h05;
  localparam logic [7:0] CMD_CLR_CONTEND = 8'h06;
  localparam logic [7:0] CMD_ADDRESS = 8'h07;
  localparam logic [7:0] CMD_MOVE_C = 8'h08;
  localparam logic [7:0] CMD_MOVE = 8'h09;
  localparam logic [7:0] CMD_STATUS = 8'h10;
  localparam logic [7:0] CMD_CONFIG = 8'h11;
  localparam logic [7:0] CMD_SWITCH = 8'h14;
  localparam logic [7:0] CMD_CLR_PATH_BASE = 8'h20;
  localparam logic [7:0] CMD_SET_PATH_BASE = 8'h24;
  localparam logic [7:0] CMD_SLEEP = 8'h30;
  localparam logic [7:0] CMD_AWAKE = 8'h31;
  localparam logic [7:0] CMD_WRITE_PORT_GROUP_ZERO = 8'h38;
  localparam logic [7:0] CMD_READ_CURRENT_FREQ = 8'h50;
  localparam logic [7:0] CMD_READ_CURRENT_ENTRY = 8'h51;
  localparam logic [7:0] CMD_READ_LOW_ENTRY = 8'h52;
  localparam logic [7:0] CMD_READ_HIGH_ENTRY = 8'h53;

  localparam logic [7:0] FRAMING_MIN = 8'hE0;
  localparam logic [7:0] FRAMING_MAX = 8'hE7;
  localparam logic [7:0] FRAMING_REPLY_A = 8'hE2;
  localparam logic [7:0] FRAMING_REPLY_B = 8'hE3;
  localparam logic [7:0] REPLY_OK = 8'hE4;
  localparam logic [7:0] ADDR_ANY = 8'h00;
  localparam logic [7:0] ADDR_ANY_LNB_SW = 8'h10;
  localparam logic [7:0] ADDR_LNB = 8'h11;
  localparam logic [7:0] ADDR_SWITCHER = 8'h14;

  localparam int STAT_RESET_BIT = 0;
  localparam int STAT_SLEEP_BIT = 1;
  localparam int STAT_VOLTAGE_BIT = 2;
  localparam int STAT_CONTEND_BIT = 7;
  localparam int PATH_BAND_BIT = 4;
  localparam int PATH_OPT_SW_BIT = 3;

  localparam logic [7:0] STATUS_RESET_VAL = 8'h01;
  localparam logic [7:0] CONFIG_VAL = 8'h03;
  localparam logic [3:0] PATH_FIXED_CAPS = 4'h7;
  localparam logic [15:0] LOW_FREQ_DIGITS = 16'h0975;
  localparam logic [7:0] LOW_TABLE_ENTRY = 8'h02;
  localparam logic [15:0] HIGH_FREQ_DIGITS = 16'h1060;
  localparam logic [7:0] HIGH_TABLE_ENTRY = 8'h04;
  localparam logic [1:0] REPLY_DATA_MAX = 2'h2;
endpackage

// >>> rtl/reply_sender.sv
// reply byte sequencer: framing byte then up to two data bytes
// assumes the downstream transmitter accepts a byte on tx_valid and tx_ready
`timescale 1ns/1ps
module reply_sender (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [1:0] data_count,
  input wire logic [7:0] data0,
  input wire logic [7:0] data1,
  output logic busy,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready
);
  typedef struct packed {
    logic active;
    logic [1:0] left;
    logic [7:0] cur;
    logic [7:0] d0;
    logic [7:0] d1;
  } snd_t;

  snd_t s_r;
  snd_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (!s_r.active) begin
      if (start) begin
        s_nxt.active = 1'b1;
        s_nxt.left = data_count;
        s_nxt.cur = cmd_decoder_pkg::REPLY_OK;
        s_nxt.d0 = data0;
        s_nxt.d1 = data1;
      end
    end else if (tx_ready) begin
      if (s_r.left == 2'h0) begin
        s_nxt.active = 1'b0;
      end else begin
        s_nxt.left = s_r.left - 2'h1;
        s_nxt.cur = s_r.d0;
        s_nxt.d0 = s_r.d1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy = s_r.active;
  assign tx_valid = s_r.active;
  assign tx_byte = s_r.cur;
endmodule

// >>> rtl/sat_bus_slave_command_decoder.sv
// command decoder of one satellite control bus slave port
// assumes a frame receiver delivering framing, address, command and data bytes
// held on frame_valid until frame_ready, and a byte transmitter for the reply
`timescale 1ns/1ps
module sat_bus_slave_command_decoder (
  input wire logic clk,
  input wire logic nrst,
  input wire logic is_lnb_mode,
  input wire logic supply_high,
  input wire logic cascade_present,
  input wire logic frame_valid,
  input wire logic [7:0] frame_framing,
  input wire logic [7:0] frame_address,
  input wire logic [7:0] frame_command,
  input wire logic frame_has_data,
  input wire logic [7:0] frame_data,
  output logic frame_ready,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  output logic [7:0] slave_bus_address,
  output logic [7:0] bus_status_flags,
  output logic [7:0] path_select
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic init_done;
    logic [7:0] addr;
    logic [7:0] status;
    logic [3:0] path_hi;
    logic opt_sw;
    logic [7:0] addr_out;
    logic [7:0] status_out;
    logic [7:0] path_out;
  } dec_t;

  dec_t d_r;
  dec_t d_nxt;

  logic snd_busy;
  logic snd_start;
  logic [1:0] snd_count;
  logic [7:0] snd_d0;
  logic [7:0] snd_d1;

  function automatic logic addr_accepted(input logic [7:0] a, input logic [7:0] own);
    addr_accepted = (a == cmd_decoder_pkg::ADDR_ANY) ||
      (a == cmd_decoder_pkg::ADDR_ANY_LNB_SW) || (a == cmd_decoder_pkg::ADDR_LNB) ||
      (a == cmd_decoder_pkg::ADDR_SWITCHER) || (a == own);
  endfunction

  function automatic logic framing_ok(input logic [7:0] f);
    framing_ok = (f >= cmd_decoder_pkg::FRAMING_MIN) && (f <= cmd_decoder_pkg::FRAMING_MAX);
  endfunction

  // ****************************************
  // decode
  // ****************************************
  logic [7:0] path_now;
  logic take;
  logic known;
  logic contend;
  logic sleeping;
  logic want_reply;
  logic hi_band;
  logic [7:0] low_ent;
  logic [7:0] high_ent;

  assign path_now = {d_r.path_hi, d_r.opt_sw, cmd_decoder_pkg::PATH_FIXED_CAPS[2:0]};
  assign contend = d_r.status[cmd_decoder_pkg::STAT_CONTEND_BIT];
  assign sleeping = d_r.status[cmd_decoder_pkg::STAT_SLEEP_BIT];
  assign hi_band = d_r.path_hi[cmd_decoder_pkg::PATH_BAND_BIT - 4];
  assign low_ent = {4'h0, cmd_decoder_pkg::LOW_TABLE_ENTRY[3:0]};
  assign high_ent = {4'h0, cmd_decoder_pkg::HIGH_TABLE_ENTRY[3:0]};
  // frames wait while a reply is still going out
  assign frame_ready = !snd_busy && d_r.init_done;
  assign take = frame_valid && frame_ready && framing_ok(frame_framing) && // R23
    addr_accepted(frame_address, d_r.addr); // R23
  assign want_reply = (frame_framing == cmd_decoder_pkg::FRAMING_REPLY_A) || // R22
    (frame_framing == cmd_decoder_pkg::FRAMING_REPLY_B); // R22

  always_comb begin
    d_nxt = d_r;
    known = 1'b1;
    snd_count = 2'h0;
    snd_d0 = 8'h00;
    snd_d1 = 8'h00;
    if (!d_r.init_done) begin
      // defaults caught after reset release, straps are not async-loaded
      d_nxt.init_done = 1'b1;
      d_nxt.addr = is_lnb_mode ? cmd_decoder_pkg::ADDR_LNB : cmd_decoder_pkg::ADDR_SWITCHER;
      d_nxt.status = cmd_decoder_pkg::STATUS_RESET_VAL;
      d_nxt.status[cmd_decoder_pkg::STAT_VOLTAGE_BIT] = supply_high; // R21
      d_nxt.opt_sw = cascade_present;
      d_nxt.path_hi = 4'h0;
    end
    if (take && sleeping && frame_command != cmd_decoder_pkg::CMD_AWAKE) begin
      known = 1'b0; // R14
    end else if (take) begin
      case (frame_command)
        cmd_decoder_pkg::CMD_RESET: begin
          d_nxt.init_done = 1'b0; // R24
        end
        cmd_decoder_pkg::CMD_CLR_RESET: begin
          d_nxt.status[cmd_decoder_pkg::STAT_RESET_BIT] = 1'b0; // R01
        end
        cmd_decoder_pkg::CMD_SET_CONTEND: begin
          d_nxt.status[cmd_decoder_pkg::STAT_CONTEND_BIT] = 1'b1; // R02
        end
        cmd_decoder_pkg::CMD_CLR_CONTEND: begin
          d_nxt.status[cmd_decoder_pkg::STAT_CONTEND_BIT] = 1'b0; // R03
        end
        cmd_decoder_pkg::CMD_CONTEND: begin
          if (contend) begin
            snd_count = 2'h1; // R04
            snd_d0 = d_r.addr;
          end
        end
        cmd_decoder_pkg::CMD_ADDRESS: begin
          if (!contend) begin
            snd_count = 2'h1; // R05
            snd_d0 = d_r.addr;
          end
        end
        cmd_decoder_pkg::CMD_MOVE_C: begin
          if (contend && frame_has_data) begin
            d_nxt.addr = frame_data; // R06
          end
        end
        cmd_decoder_pkg::CMD_MOVE: begin
          if (!contend && frame_has_data) begin
            d_nxt.addr = frame_data; // R07
          end
        end
        cmd_decoder_pkg::CMD_STATUS: begin
          snd_count = 2'h1; // R08
          snd_d0 = d_r.status;
        end
        cmd_decoder_pkg::CMD_CONFIG: begin
          snd_count = 2'h1; // R09
          snd_d0 = cmd_decoder_pkg::CONFIG_VAL;
        end
        cmd_decoder_pkg::CMD_SWITCH: begin
          snd_count = 2'h1; // R09
          snd_d0 = path_now;
        end
        // low two command bits pick the path bit, so one arm serves four commands
        cmd_decoder_pkg::CMD_CLR_PATH_BASE,
        cmd_decoder_pkg::CMD_CLR_PATH_BASE + 8'h01,
        cmd_decoder_pkg::CMD_CLR_PATH_BASE + 8'h02,
        cmd_decoder_pkg::CMD_CLR_PATH_BASE + 8'h03: begin
          d_nxt.path_hi[frame_command[1:0]] = 1'b0; // R10 R11 R12 R13
        end
        cmd_decoder_pkg::CMD_SET_PATH_BASE,
        cmd_decoder_pkg::CMD_SET_PATH_BASE + 8'h01,
        cmd_decoder_pkg::CMD_SET_PATH_BASE + 8'h02,
        cmd_decoder_pkg::CMD_SET_PATH_BASE + 8'h03: begin
          d_nxt.path_hi[frame_command[1:0]] = 1'b1; // R10 R11 R12 R13
        end
        cmd_decoder_pkg::CMD_SLEEP: d_nxt.status[cmd_decoder_pkg::STAT_SLEEP_BIT] = 1'b1; // R14
        cmd_decoder_pkg::CMD_AWAKE: d_nxt.status[cmd_decoder_pkg::STAT_SLEEP_BIT] = 1'b0; // R15
        cmd_decoder_pkg::CMD_WRITE_PORT_GROUP_ZERO: begin
          // each nibble bit pair: upper clears, lower sets, both zero keeps
          if (frame_has_data) begin
            for (int i = 0; i < 4; i++) begin
              if (frame_data[i]) begin
                d_nxt.path_hi[i] = 1'b1; // R16
              end else if (frame_data[i + 4]) begin
                d_nxt.path_hi[i] = 1'b0; // R16
              end
            end
          end
        end
        cmd_decoder_pkg::CMD_READ_CURRENT_FREQ: begin
          snd_count = cmd_decoder_pkg::REPLY_DATA_MAX; // R17
          snd_d0 = hi_band ? cmd_decoder_pkg::HIGH_FREQ_DIGITS[15:8] :
            cmd_decoder_pkg::LOW_FREQ_DIGITS[15:8];
          snd_d1 = hi_band ? cmd_decoder_pkg::HIGH_FREQ_DIGITS[7:0] :
            cmd_decoder_pkg::LOW_FREQ_DIGITS[7:0];
        end
        cmd_decoder_pkg::CMD_READ_CURRENT_ENTRY: begin
          snd_count = 2'h1; // R18
          snd_d0 = hi_band ? high_ent : low_ent;
        end
        cmd_decoder_pkg::CMD_READ_LOW_ENTRY: begin
          snd_count = 2'h1; // R19
          snd_d0 = low_ent;
        end
        cmd_decoder_pkg::CMD_READ_HIGH_ENTRY: begin
          snd_count = 2'h1; // R20
          snd_d0 = high_ent;
        end
        default: known = 1'b0; // R25
      endcase
    end else begin
      known = 1'b0;
    end
    d_nxt.addr_out = d_nxt.addr;
    d_nxt.status_out = d_nxt.status;
    d_nxt.path_out = {d_nxt.path_hi, d_nxt.opt_sw, cmd_decoder_pkg::PATH_FIXED_CAPS[2:0]};
  end

  // silent on framings that ask for no reply and on ignored commands
  assign snd_start = take && known && want_reply; // R22 R25

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      d_r <= '0;
    end else begin
      d_r <= d_nxt;
    end
  end

  assign slave_bus_address = d_r.addr_out;
  assign bus_status_flags = d_r.status_out;
  assign path_select = d_r.path_out;

  // ****************************************
  // reply
  // ****************************************
  reply_sender u_reply (
    .clk(clk),
    .nrst(nrst),
    .start(snd_start),
    .data_count(snd_count),
    .data0(snd_d0),
    .data1(snd_d1),
    .busy(snd_busy),
    .tx_valid(tx_valid),
    .tx_byte(tx_byte),
    .tx_ready(tx_ready)
  );
endmodule

// >>> verif/cmd_decoder_checker.sv
// port assertions for the command decoder
// assumes binding onto the decoder top, one clock domain
`timescale 1ns/1ps
module cmd_decoder_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic frame_valid,
  input wire logic frame_ready,
  input wire logic [7:0] frame_framing,
  input wire logic [7:0] frame_address,
  input wire logic [7:0] frame_command,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_ready,
  input wire logic [7:0] bus_status_flags,
  input wire logic [7:0] path_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // awake frame, any-device address, framing in range
  sequence s_take(logic [7:0] c);
    frame_valid && frame_ready && frame_address == 8'h00 && !bus_status_flags[1] &&
      frame_framing[7:3] == 5'h1C && frame_command == c;
  endsequence
  sequence s_quiet;
    !tx_valid [*3];
  endsequence
  a_clr_reset: assert property (s_take(8'h01) |=> !bus_status_flags[0])
    else $error("reset flag kept");
  a_set_contend: assert property (s_take(8'h04) |=> bus_status_flags[7])
    else $error("contention flag not set");
  a_clr_contend: assert property (s_take(8'h06) |=> !bus_status_flags[7])
    else $error("contention flag not cleared");
  a_band_high: assert property (s_take(8'h24) |=> path_select[4])
    else $error("band bit not set");
  a_pol_low: assert property (s_take(8'h21) |=> !path_select[5])
    else $error("polarization bit not cleared");
  a_sleep_set: assert property (s_take(8'h30) |=> bus_status_flags[1])
    else $error("sleep bit not set");
  a_sleep_ignore: assert property (bus_status_flags[1] && frame_valid && frame_ready &&
    frame_command == 8'h24 |=> $stable(path_select)) else $error("command obeyed asleep");
  a_reply_head: assert property ($rose(tx_valid) |-> tx_byte == 8'hE4 && !frame_ready)
    else $error("bad reply head");
  a_no_reply: assert property (s_take(8'h10) ##0 frame_framing[2:1] != 2'h1 |=> s_quiet)
    else $error("unasked reply");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("reply byte dropped");
endmodule
bind sat_bus_slave_command_decoder cmd_decoder_checker cmd_decoder_checker_i (
  .clk(clk), .nrst(nrst), .frame_valid(frame_valid), .frame_ready(frame_ready),
  .frame_framing(frame_framing), .frame_address(frame_address),
  .frame_command(frame_command), .tx_valid(tx_valid), .tx_byte(tx_byte),
  .tx_ready(tx_ready), .bus_status_flags(bus_status_flags), .path_select(path_select));

// >>> verif/reply_sink_model.sv
// receiving side of the bus master, collecting reply bytes
// assumes bytes pass on tx_valid and tx_ready at the rising edge
`timescale 1ns/1ps
module reply_sink_model (
  input wire logic clk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready
);
  logic [2:0] cnt = 3'h0;
  logic [7:0] got_q[$];
  // stalls two cycles in eight so held bytes are exercised
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got_q.push_back(tx_byte);
    cnt <= cnt + 3'h1;
    tx_ready <= #2 (cnt[2:1] != 2'h3);
  end
endmodule

// >>> verif/sat_bus_slave_command_decoder_tb.sv
// self-checking bench for the command decoder
// assumes the reply sink model stands on the reply side
`timescale 1ns/1ps
module sat_bus_slave_command_decoder_tb;
  logic clk = 0, nrst = 0, lnb = 0, sup = 0, casc = 0, fv = 0, fhd = 0;
  logic [7:0] ffr = 8'h00, fad = 8'h00, fcm = 8'h00, fdt = 8'h00;
  logic fr, txv, txr;
  logic [7:0] txb, adr, stf, pth;
  int error_cnt = 0, num_checks = 0, m_adr, m_st, m_pth, rnd = 56;
  int exp_q[$];
  logic [7:0] cmds[$] = '{8'h01, 8'h10, 8'h04, 8'h05, 8'h08, 8'h10, 8'h09, 8'h06, 8'h07,
    8'h09, 8'h07, 8'h11, 8'h14, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27,
    8'h14, 8'h50, 8'h51, 8'h52, 8'h53, 8'h20, 8'h50, 8'h51, 8'h38, 8'h14, 8'h38, 8'h3F,
    8'h30, 8'h24, 8'h04, 8'h10, 8'h31, 8'h10, 8'h00, 8'h10};
  sat_bus_slave_command_decoder sat_bus_slave_command_decoder_i (.clk(clk), .nrst(nrst),
    .is_lnb_mode(lnb), .supply_high(sup), .cascade_present(casc), .frame_valid(fv),
    .frame_framing(ffr), .frame_address(fad), .frame_command(fcm), .frame_has_data(fhd),
    .frame_data(fdt), .frame_ready(fr), .tx_valid(txv), .tx_byte(txb), .tx_ready(txr),
    .slave_bus_address(adr), .bus_status_flags(stf), .path_select(pth));
  reply_sink_model reply_sink_model_i (.clk(clk), .tx_valid(txv), .tx_byte(txb),
    .tx_ready(txr));
  initial forever #25 clk = ~clk;
  function automatic int lfsr(int v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk_reply(logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t reply %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t register %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_regs();
    chk_reg(adr, m_adr[7:0]);
    chk_reg(stf, m_st[7:0]);
    chk_reg(pth, m_pth[7:0]);
  endtask
  task automatic reinit();
    m_st = 1 | (sup << 2);
    m_adr = lnb ? 'h11 : 'h14;
    m_pth = (casc << 3) | 7;
  endtask
  // ****************************************
  // reference model of one frame
  // ****************************************
  task automatic model(logic [7:0] f, logic [7:0] c, logic [7:0] d, logic hd);
    bit ok, ct;
    ok = 1;
    ct = m_st[7];
    exp_q = {};
    if (f[7:3] != 5'h1C) return;
    if (!(fad inside {8'h00, 8'h10, 8'h11, 8'h14}) && fad != m_adr[7:0]) return;
    if (m_st[1] && c != 8'h31) ok = 0;
    else case (c)
      8'h00: reinit();
      8'h01: m_st[0] = 0;
      8'h04: m_st[7] = 1;
      8'h06: m_st[7] = 0;
      8'h05: if (ct) exp_q = {m_adr};
      8'h07: if (!ct) exp_q = {m_adr};
      8'h08: if (ct && hd) m_adr = d;
      8'h09: if (!ct && hd) m_adr = d;
      8'h10: exp_q = {m_st};
      8'h11: exp_q.push_back(3);
      8'h14: exp_q = {m_pth};
      8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27: m_pth[c[1:0] + 4] = c[2];
      8'h30: m_st[1] = 1;
      8'h31: m_st[1] = 0;
      8'h38: if (hd) m_pth[7:4] = (m_pth[7:4] & ~d[7:4]) | d[3:0];
      8'h50: begin
        exp_q.push_back(m_pth[4] ? 'h10 : 'h09);
        exp_q.push_back(m_pth[4] ? 'h60 : 'h75);
      end
      8'h51: exp_q.push_back(m_pth[4] ? 4 : 2);
      8'h52: exp_q.push_back(2);
      8'h53: exp_q.push_back(4);
      default: ok = 0;
    endcase
    if (ok && f[2:1] == 2'h1) exp_q.push_front(cmd_decoder_pkg::REPLY_OK);
    else exp_q = {};
  endtask
  task automatic frame(logic [7:0] f, logic [7:0] c);
    int n;
    logic [7:0] d;
    logic hd;
    d = rnd[7:0];
    rnd = lfsr(rnd);
    hd = c inside {8'h08, 8'h09, 8'h38};
    model(f, c, d, hd);
    @(posedge clk);
    #2;
    {fv, ffr, fcm, fdt, fhd} = {1'b1, f, c, d, hd};
    n = 0;
    while (fr !== 1'b1 && n < 50) begin
      @(posedge clk);
      #2;
      n++;
    end
    if (fr !== 1'b1) begin
      error_cnt++;
      $display("mismatch %0t frame never taken", $time);
    end
    @(posedge clk);
    #2 fv = 0;
    n = 0;
    while (reply_sink_model_i.got_q.size() < exp_q.size() && n < 60) begin
      @(posedge clk);
      n++;
    end
    repeat (4) @(posedge clk);
    #2;
    chk_reply(8'(reply_sink_model_i.got_q.size()), 8'(exp_q.size()));
    foreach (exp_q[i]) begin
      chk_reply(reply_sink_model_i.got_q[i], 8'(exp_q[i]));
    end
    reply_sink_model_i.got_q = {};
    chk_regs();
  endtask
  task automatic do_reset();
    #2 nrst = 0;
    {lnb, sup, casc} = rnd[2:0];
    rnd = lfsr(rnd);
    repeat (10) @(posedge clk);
    #2 nrst = 1;
    @(posedge clk);
    #2 reinit();
    chk_regs();
  endtask
  initial begin
    #1000000 error_cnt++;
    $display("mismatch %0t watchdog expired", $time);
    summarize();
  end
  initial begin
    do_reset();
    foreach (cmds[i]) frame(i % 3 ? 8'hE2 : 8'hE3, cmds[i]);
    do_reset();
    frame(8'hE0, 8'h10);
    frame(8'hF0, 8'h24);
    frame(8'hE1, 8'h24);
    frame(8'hE2, 8'h14);
    fad = 8'h12;
    frame(8'hE3, 8'h20);
    fad = 8'h14;
    frame(8'hE2, 8'h14);
    summarize();
  end
endmodule
